// [tb_tsh_host.sv]
// Self-checking bench for the sensor host controller
`timescale 1ns/1ns
module tb_tsh_host;
    import tsh_pkg::*;

    localparam int PWR = 200;
    localparam int GAP = 200;

    logic clk = 0, rst = 1, cmd_valid = 0, cmd_read = 0, cmd_with_data = 0;
    logic cmd_read_crc = 0, cmd_addr_sel = 0, reset_req = 0;
    logic addr_fault = 0, over_limit = 0;
    logic [15:0] cmd_code = '0, cmd_wdata = '0, rd_data;
    logic [31:0] stretch_ns = '0;
    logic [23:0] rd_bytes = '0;
    logic cmd_ready, done, nack, crc_ok, alert, scl_out, scl_oe_n, sda_out;
    logic sda_oe_n, addr_pin, reset_in_low_active, alert_in;
    logic scl_pull, sda_pull, scl, sda;
    int fail_count = 0, checked = 0;

    // Pull-ups: a line is low only while some party pulls it
    assign scl = !(scl_oe_n === 1'b0 || scl_pull);
    assign sda = !(sda_oe_n === 1'b0 || sda_pull);
    always #5 clk = ~clk;

    tsh_host #(.POWER_CYC(PWR), .GAP_CYC(GAP)) dut (
        .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
        .cmd_with_data(cmd_with_data), .cmd_read_crc(cmd_read_crc),
        .cmd_addr_sel(cmd_addr_sel), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .reset_req(reset_req), .cmd_ready(cmd_ready),
        .done(done), .nack(nack), .crc_ok(crc_ok), .rd_data(rd_data),
        .alert(alert), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_pin(addr_pin), .reset_in_low_active(reset_in_low_active),
        .alert_in(alert_in));

    tsh_sensor_model #(.POWER_NS(PWR * 10), .GAP_NS(GAP * 10)) u_sen (
        .scl(scl), .sda(sda), .scl_pull(scl_pull), .sda_pull(sda_pull),
        .addr_pin(addr_pin), .reset_in_low_active(reset_in_low_active),
        .alert_out(alert_in), .addr_fault(addr_fault),
        .over_limit(over_limit), .stretch_ns(stretch_ns),
        .rd_bytes(rd_bytes));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic xfer(input logic rd, input logic wd, input logic rc,
        input logic sel, input logic [15:0] code, input logic [15:0] wdata);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 10000)
        begin
            @(posedge clk);
            n++;
        end
        {cmd_read, cmd_with_data} <= {rd, wd};
        {cmd_read_crc, cmd_addr_sel} <= {rc, sel};
        cmd_code <= code;
        cmd_wdata <= wdata;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        check("done", 16'h1, {15'h0, done});
    endtask

    task automatic t_measure();
        xfer(0, 0, 0, 0, 16'h2C06, 16'h0);
        check("nack", 16'h0, {15'h0, nack});
        check("bytes", 16'h2, 16'(u_sen.rx_n));
        check("command", 16'h2C06, {u_sen.rx[0], u_sen.rx[1]});
        xfer(0, 0, 0, 1, 16'h2400, 16'h0);
        check("command", 16'h2400, {u_sen.rx[0], u_sen.rx[1]});
        check("conversions", 16'h2, 16'(u_sen.convs));
    endtask

    task automatic t_wrong_addr();
        addr_fault <= 1'b1;
        xfer(0, 0, 0, 0, 16'h2C0D, 16'h0);
        check("nack", 16'h1, {15'h0, nack});
        check("bytes", 16'h0, 16'(u_sen.rx_n));
        addr_fault <= 1'b0;
    endtask

    task automatic t_write_data();
        xfer(0, 1, 0, 0, 16'hE000, 16'hBEEF);
        check("bytes", 16'h5, 16'(u_sen.rx_n));
        check("data", 16'hBEEF, {u_sen.rx[2], u_sen.rx[3]});
        check("crc", 16'h0092, {8'h00, u_sen.rx[4]});
    endtask

    task automatic t_read();
        rd_bytes <= 24'hBEEF92;
        stretch_ns <= 32'hBB8;
        xfer(1, 0, 1, 0, 16'h0, 16'h0);
        check("word", 16'hBEEF, rd_data);
        check("crc ok", 16'h1, {15'h0, crc_ok});
        stretch_ns <= 32'h0;
        rd_bytes <= 24'h000080;
        xfer(1, 0, 1, 1, 16'h0, 16'h0);
        check("word", 16'h0000, rd_data);
        check("crc ok", 16'h0, {15'h0, crc_ok});
        rd_bytes <= 24'h5A5A00;
        xfer(1, 0, 0, 0, 16'h0, 16'h0);
        check("word", 16'h5A5A, rd_data);
        check("crc ok", 16'h0, {15'h0, crc_ok});
    endtask

    task automatic t_alert();
        over_limit <= 1'b1;
        repeat (5) @(posedge clk);
        check("alert", 16'h1, {15'h0, alert});
        over_limit <= 1'b0;
        repeat (5) @(posedge clk);
        check("alert", 16'h0, {15'h0, alert});
    endtask

    task automatic t_reset();
        while (cmd_ready !== 1'b1)
            @(posedge clk);
        reset_req <= 1'b1;
        @(posedge clk);
        reset_req <= 1'b0;
        @(posedge clk);
        check("ready", 16'h0, {15'h0, cmd_ready});
        xfer(0, 0, 0, 0, 16'h2C10, 16'h0);
        check("resets", 16'h2, 16'(u_sen.resets));
        check("command", 16'h2C10, {u_sen.rx[0], u_sen.rx[1]});
    endtask

    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_measure();
        t_wrong_addr();
        t_write_data();
        t_read();
        t_alert();
        t_reset();
        check("early", 16'h0, 16'(u_sen.viol));
        report_and_stop();
    end

    // About ten transfers of a few thousand cycles each fit well inside this
    initial
    begin
        #1000000;
        fail_count++;
        report_and_stop();
    end
endmodule

// [tsh_host.sv]
// Host controller driving the temperature sensor over its two-wire pins
`timescale 1ns/1ns
module tsh_host
    import tsh_pkg::*;
#(
    parameter int POWER_CYC = tsh_pkg::POWER_UP_CYC,
    parameter int GAP_CYC = tsh_pkg::CMD_GAP_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // User command port
    input wire logic cmd_valid,
    input wire logic cmd_read,
    input wire logic cmd_with_data,
    input wire logic cmd_read_crc,
    input wire logic cmd_addr_sel,
    input wire logic [15:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic reset_req,
    output logic cmd_ready,
    // User results
    output logic done,
    output logic nack,
    output logic crc_ok,
    output logic [15:0] rd_data,
    output logic alert,
    // Sensor pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic addr_pin,
    output logic reset_in_low_active,
    input wire logic alert_in
);
    import tsh_pkg::*;

    typedef struct packed {
        tsh_state_t st;
        logic [19:0] timer;
        logic [3:0] bit_cnt;
        logic [2:0] byte_idx;
        logic [7:0] shreg;
        logic [15:0] rx_word;
        logic [7:0] rx_crc;
        logic op_read;
        logic op_data;
        logic op_crc;
        logic [15:0] cmd;
        logic [15:0] wdata;
        logic scl_oe_n;
        logic sda_oe_n;
        logic rst_pin;
        logic addr_pin;
        logic ready;
        logic done;
        logic nack;
        logic crc_ok;
        logic [15:0] data;
        logic alert;
    } tsh_regs_t;

    tsh_regs_t cur;
    tsh_regs_t next_cur;
    logic [2:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic alert_s;

    tsh_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({scl_in, sda_in, ~alert_in}),
        .sync_out(pins_s)
    );
    assign scl_s = pins_s[2];
    assign sda_s = pins_s[1];
    // Alert idles low, so it passes inverted to avoid a false alert at reset
    assign alert_s = ~pins_s[0];

    function automatic logic timer_at(input logic [19:0] t, input int n);
        return t == 20'(n - 1);
    endfunction

    function automatic logic [2:0] byte_total(input tsh_regs_t r);
        if (r.op_read)
            return r.op_crc ? RD_BYTES_CRC : RD_BYTES_WORD;
        return r.op_data ? WR_BYTES_DATA : WR_BYTES_CMD;
    endfunction

    function automatic logic [7:0] tx_byte(input tsh_regs_t r,
        input logic [2:0] idx);
        case (idx)
            IDX_ADDR: tx_byte = {(r.addr_pin ? ADDR_SEL_HIGH : ADDR_SEL_LOW),
                (r.op_read ? RW_READ : RW_WRITE)};
            IDX_HI: tx_byte = r.cmd[15:8];
            IDX_LO: tx_byte = r.cmd[7:0];
            IDX_DHI: tx_byte = r.wdata[15:8];
            IDX_DLO: tx_byte = r.wdata[7:0];
            default: tx_byte = tsh_crc8(r.wdata);
        endcase
    endfunction

    always_comb
    begin
        logic is_tx;
        logic is_last;
        is_tx = !cur.op_read || cur.byte_idx == IDX_ADDR;
        is_last = cur.byte_idx == byte_total(cur) - 3'h1;
        next_cur = cur;
        next_cur.timer = cur.timer + 20'h1;
        next_cur.done = 1'b0;
        next_cur.alert = alert_s;
        case (cur.st)
            ST_RESET:
            begin
                next_cur.rst_pin = 1'b0;
                if (timer_at(cur.timer, RESET_PULSE_CYC))
                begin
                    next_cur.rst_pin = 1'b1;
                    next_cur.timer = '0;
                    next_cur.st = ST_POWER;
                end
            end
            ST_POWER:
            begin
                // Wait the worst-case power-up before the first command
                if (timer_at(cur.timer, POWER_CYC))
                begin
                    next_cur.st = ST_IDLE;
                    next_cur.ready = 1'b1;
                end
            end
            ST_IDLE:
            begin
                next_cur.timer = '0;
                if (reset_req)
                begin
                    next_cur.ready = 1'b0;
                    next_cur.rst_pin = 1'b0;
                    next_cur.st = ST_RESET;
                end
                else if (cmd_valid)
                begin
                    next_cur.ready = 1'b0;
                    next_cur.op_read = cmd_read;
                    next_cur.op_data = cmd_with_data;
                    next_cur.op_crc = cmd_read_crc;
                    next_cur.cmd = cmd_code;
                    next_cur.wdata = cmd_wdata;
                    next_cur.addr_pin = cmd_addr_sel;
                    next_cur.nack = 1'b0;
                    next_cur.crc_ok = 1'b0;
                    next_cur.sda_oe_n = 1'b0;
                    next_cur.st = ST_START;
                end
            end
            ST_START:
            begin
                if (timer_at(cur.timer, SCL_HALF_CYC))
                begin
                    next_cur.timer = '0;
                    next_cur.scl_oe_n = 1'b0;
                    next_cur.bit_cnt = '0;
                    next_cur.byte_idx = IDX_ADDR;
                    next_cur.shreg = tx_byte(cur, IDX_ADDR);
                    next_cur.st = ST_BIT_LOW;
                end
            end
            ST_BIT_LOW:
            begin
                // Change data a little after the falling clock edge
                if (timer_at(cur.timer, SDA_HOLD_CYC))
                begin
                    if (cur.bit_cnt != ACK_SLOT)
                        next_cur.sda_oe_n = is_tx ? cur.shreg[7] : 1'b1;
                    else
                        next_cur.sda_oe_n = is_tx ? 1'b1 : is_last;
                end
                if (timer_at(cur.timer, SCL_HALF_CYC))
                begin
                    next_cur.timer = '0;
                    next_cur.scl_oe_n = 1'b1;
                    next_cur.st = ST_BIT_HIGH;
                end
            end
            ST_BIT_HIGH:
            begin
                // Half period counts only once the sensor lets go
                if (!scl_s)
                    next_cur.timer = '0;
                else if (timer_at(cur.timer, SCL_HALF_CYC))
                begin
                    next_cur.timer = '0;
                    next_cur.scl_oe_n = 1'b0;
                    next_cur.st = ST_BIT_LOW;
                    if (cur.bit_cnt != ACK_SLOT)
                    begin
                        next_cur.shreg = {cur.shreg[6:0], sda_s};
                        next_cur.bit_cnt = cur.bit_cnt + 4'h1;
                    end
                    else if (is_tx && sda_s)
                    begin
                        next_cur.nack = 1'b1;
                        next_cur.st = ST_STOP_LOW;
                    end
                    else
                    begin
                        if (cur.byte_idx == IDX_HI && cur.op_read)
                            next_cur.rx_word[15:8] = cur.shreg;
                        if (cur.byte_idx == IDX_LO && cur.op_read)
                            next_cur.rx_word[7:0] = cur.shreg;
                        if (cur.byte_idx == IDX_DHI && cur.op_read)
                            next_cur.rx_crc = cur.shreg;
                        // Last command byte ack starts the conversion
                        if (is_last)
                            next_cur.st = ST_STOP_LOW;
                        else
                        begin
                            next_cur.bit_cnt = '0;
                            next_cur.byte_idx = cur.byte_idx + 3'h1;
                            next_cur.shreg = tx_byte(cur,
                                cur.byte_idx + 3'h1);
                        end
                    end
                end
            end
            ST_STOP_LOW:
            begin
                if (timer_at(cur.timer, SDA_HOLD_CYC))
                    next_cur.sda_oe_n = 1'b0;
                if (timer_at(cur.timer, SCL_HALF_CYC))
                begin
                    next_cur.timer = '0;
                    next_cur.scl_oe_n = 1'b1;
                    next_cur.st = ST_STOP_HIGH;
                end
            end
            ST_STOP_HIGH:
            begin
                if (!scl_s)
                    next_cur.timer = '0;
                else if (timer_at(cur.timer, SCL_HALF_CYC))
                begin
                    next_cur.timer = '0;
                    next_cur.sda_oe_n = 1'b1;
                    next_cur.st = ST_STOP_END;
                end
            end
            ST_STOP_END:
            begin
                if (timer_at(cur.timer, SCL_HALF_CYC))
                begin
                    next_cur.timer = '0;
                    next_cur.done = 1'b1;
                    next_cur.data = cur.rx_word;
                    next_cur.crc_ok = cur.op_read && cur.op_crc && !cur.nack
                        && tsh_crc8(cur.rx_word) == cur.rx_crc;
                    next_cur.st = ST_GAP;
                end
            end
            ST_GAP:
            begin
                // Bus idle time also covers the sensor's command recovery
                if (timer_at(cur.timer, GAP_CYC))
                begin
                    next_cur.ready = 1'b1;
                    next_cur.st = ST_IDLE;
                end
            end
            default:
            begin
                next_cur.timer = '0;
                next_cur.st = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cur <= '0;
            cur.st <= ST_RESET;
            cur.scl_oe_n <= 1'b1;
            cur.sda_oe_n <= 1'b1;
            cur.rst_pin <= 1'b0;
        end
        else
            cur <= next_cur;
    end

    assign cmd_ready = cur.ready;
    assign done = cur.done;
    assign nack = cur.nack;
    assign crc_ok = cur.crc_ok;
    assign rd_data = cur.data;
    assign alert = cur.alert;
    assign scl_oe_n = cur.scl_oe_n;
    assign sda_oe_n = cur.sda_oe_n;
    // Open-drain: only ever a low level, gated by the enables
    assign scl_out = cur.ready & 1'b0;
    assign sda_out = cur.ready & 1'b0;
    assign addr_pin = cur.addr_pin;
    assign reset_in_low_active = cur.rst_pin;
endmodule

// [tsh_host_asserts.sv]
// Checker for the sensor host command port and pin timing
`timescale 1ns/1ns
module tsh_host_asserts
    import tsh_pkg::*;
#(
    parameter int POWER_CYC = 100000,
    parameter int GAP_CYC = 100000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command port
    input wire logic cmd_valid,
    input wire logic cmd_addr_sel,
    input wire logic reset_req,
    input wire logic cmd_ready,
    input wire logic done,
    input wire logic nack,
    input wire logic alert,
    // Sensor pins
    input wire logic scl_out,
    input wire logic scl_oe_n,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic addr_pin,
    input wire logic reset_in_low_active,
    input wire logic alert_in
);
    logic [31:0] low_cnt;
    logic [31:0] rel_cnt;
    logic [31:0] gap_cnt;
    logic seen_done;
    logic take;

    assign take = cmd_ready && cmd_valid && !reset_req;

    // Counters, since the waits are far too long for repetition
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            low_cnt <= '0;
            rel_cnt <= '0;
            gap_cnt <= '0;
            seen_done <= 1'b0;
        end
        else
        begin
            low_cnt <= reset_in_low_active ? '0 : low_cnt + 1;
            rel_cnt <= reset_in_low_active ? rel_cnt + 1 : '0;
            gap_cnt <= done ? '0 : gap_cnt + 1;
            seen_done <= reset_in_low_active && (seen_done || done);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    idle_released_a: assert property (cmd_ready
        |-> scl_oe_n && sda_oe_n)
        else $error("bus held while idle");
    start_cond_a: assert property (take |=>
        (scl_oe_n && !sda_oe_n && !cmd_ready) [*8])
        else $error("no start after accept");
    addr_select_a: assert property (take
        |=> addr_pin == $past(cmd_addr_sel))
        else $error("address pin wrong");
    addr_steady_a: assert property (!cmd_ready && !$past(cmd_ready)
        |-> $stable(addr_pin))
        else $error("address pin moved in transfer");
    open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("line driven high");
    stop_done_a: assert property (done
        |-> scl_oe_n && sda_oe_n ##1 !done)
        else $error("done without stop");
    reset_pulse_a: assert property ($rose(reset_in_low_active)
        |-> low_cnt >= RESET_PULSE_CYC - 2)
        else $error("reset pulse short");
    power_wait_a: assert property ($rose(cmd_ready)
        |-> rel_cnt >= POWER_CYC - 2)
        else $error("ready before power-up");
    cmd_gap_a: assert property (seen_done && $rose(cmd_ready)
        |-> gap_cnt >= GAP_CYC - 2)
        else $error("command gap short");
    alert_follow_a: assert property (alert == $past(alert_in, 3))
        else $error("alert not following pin");

    cover property (take);
    cover property (done && nack);
    cover property ($rose(reset_in_low_active));
endmodule

bind tsh_host tsh_host_asserts #(.POWER_CYC(POWER_CYC), .GAP_CYC(GAP_CYC))
    u_chk (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_addr_sel(cmd_addr_sel), .reset_req(reset_req),
    .cmd_ready(cmd_ready), .done(done), .nack(nack), .alert(alert),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_pin(addr_pin),
    .reset_in_low_active(reset_in_low_active), .alert_in(alert_in));

// [tsh_pkg.sv]
// Constants, types and helpers shared by the temperature sensor host
package tsh_pkg;

    // Clock and bus timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_HALF_NS = 500;
    localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int SDA_HOLD_CYC = 5;

    // Reset pulse and waits
    localparam int RESET_PULSE_US = 1;
    localparam int RESET_PULSE_CYC = (RESET_PULSE_US * 1000
        + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_UP_MS = 1;
    localparam int POWER_UP_CYC = (POWER_UP_MS * 1000000
        + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CMD_GAP_MS = 1;
    localparam int CMD_GAP_CYC = (CMD_GAP_MS * 1000000
        + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Sensor addressing
    localparam logic [6:0] ADDR_SEL_LOW = 7'h4A;
    localparam logic [6:0] ADDR_SEL_HIGH = 7'h4B;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;

    // Transfer shape
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [2:0] WR_BYTES_CMD = 3'h3;
    localparam logic [2:0] WR_BYTES_DATA = 3'h6;
    localparam logic [2:0] RD_BYTES_WORD = 3'h3;
    localparam logic [2:0] RD_BYTES_CRC = 3'h4;
    localparam logic [2:0] IDX_ADDR = 3'h0;
    localparam logic [2:0] IDX_HI = 3'h1;
    localparam logic [2:0] IDX_LO = 3'h2;
    localparam logic [2:0] IDX_DHI = 3'h3;
    localparam logic [2:0] IDX_DLO = 3'h4;

    // Data checksum
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hFF;

    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_POWER = 4'h1,
        ST_IDLE = 4'h3,
        ST_START = 4'h2,
        ST_BIT_LOW = 4'h6,
        ST_BIT_HIGH = 4'h7,
        ST_STOP_LOW = 4'h5,
        ST_STOP_HIGH = 4'h4,
        ST_STOP_END = 4'hC,
        ST_GAP = 4'hD
    } tsh_state_t;

    function automatic logic [7:0] tsh_crc8(input logic [15:0] word);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--)
        begin
            if (c[7] ^ word[i])
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            else
                c = {c[6:0], 1'b0};
        end
        return c;
    endfunction

endpackage

// [tsh_sensor_model.sv]
// Behavioural temperature sensor on the open-drain two-wire bus
`timescale 1ns/1ns
module tsh_sensor_model #(
    parameter int POWER_NS = 2000,
    parameter int GAP_NS = 2000
) (
    // Wired levels and this device's pull-downs
    input wire logic scl,
    input wire logic sda,
    output logic scl_pull,
    output logic sda_pull,
    // Side pins
    input wire logic addr_pin,
    input wire logic reset_in_low_active,
    output logic alert_out,
    // Bench controls
    input wire logic addr_fault,
    input wire logic over_limit,
    input wire logic [31:0] stretch_ns,
    input wire logic [23:0] rd_bytes
);
    logic [7:0] sr = '0;
    logic [7:0] rx [0:7];
    logic active = 0, ready = 0, match = 0, rd = 0, hnack = 0;
    int bitn = 0, idx = 0, rx_n = 0, viol = 0, resets = 0, convs = 0;
    time low_at = 0, last_stop = 0;

    initial
    begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    assign alert_out = over_limit;

    always @(negedge reset_in_low_active)
        low_at = $time;

    // Idle is reached unprompted once the power-up time has run out
    always @(posedge reset_in_low_active)
    begin
        active = 0;
        sda_pull = 1'b0;
        ready = 0;
        if ($time - low_at >= 1000)
            resets++;
        #(POWER_NS) ready = 1;
    end

    always @(negedge sda)
        if (scl === 1'b1)
        begin
            if (!ready || $time - last_stop < GAP_NS)
                viol++;
            {active, match, rd, hnack} = 4'b1000;
            bitn = 0;
            idx = 0;
            rx_n = 0;
        end

    always @(posedge sda)
        if (scl === 1'b1 && active)
        begin
            active = 0;
            last_stop = $time;
        end

    always @(posedge scl)
        if (active)
        begin
            if (bitn < 8)
                sr = {sr[6:0], sda};
            else if (rd && sda)
                hnack = 1;
            bitn++;
        end

    always @(negedge scl)
        if (active)
        begin
            if (bitn == 9)
            begin
                bitn = 0;
                idx++;
            end
            if (bitn == 8)
            begin
                if (idx == 0)
                begin
                    match = sr[7:1]
                        == {6'h25, addr_pin ^ addr_fault};
                    rd = sr[0];
                end
                else if (match && !rd && rx_n < 8)
                begin
                    rx[rx_n] = sr;
                    rx_n++;
                end
                // Conversion starts with the ack of the last command byte
                if (match && !rd && idx == 2)
                    convs++;
                sda_pull = match && (idx == 0 || !rd);
            end
            else
            begin
                // Data settles while SCL is low, never as the stretch ends
                sda_pull = rd && match && idx > 0 && idx < 4 && !hnack
                    && !rd_bytes[8 * (3 - idx) + 7 - bitn];
                if (rd && match && idx == 1 && bitn == 0 && stretch_ns > 0)
                begin
                    scl_pull = 1'b1;
                    #(stretch_ns) scl_pull = 1'b0;
                end
            end
        end
endmodule

// [tsh_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module tsh_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Asynchronous in, synchronised out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // Pins idle high under pull-ups, so reset to ones
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta <= '1;
            sync_out <= '1;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule
